/* File: src/dtc_edge_sync.sv */
// Three-stage synchroniser with agreed-level falling edge detect for one pin.
`timescale 1ns/1ns
module dtc_edge_sync (
    input  wire logic clk,      // System clock.
    input  wire logic sys_rst,  // Synchronous reset, active high.
    input  wire logic pin,      // Asynchronous pin.
    output logic      level,    // Filtered pin level.
    output logic      fall      // One-cycle pulse on a filtered falling edge.
);
    logic [2:0] stage;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stage <= 3'h7;
        end else begin
            stage <= {stage[1:0], pin};
        end
    end

    // The level moves only when the second and third stages agree.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            level <= 1'b1;
            fall  <= 1'b0;
        end else begin
            fall <= 1'b0;
            if (stage[1] == stage[2] && stage[2] != level) begin
                level <= stage[2];
                fall  <= level & ~stage[2];
            end
        end
    end
endmodule // dtc_edge_sync

/* File: src/dtc_pkg.sv */
// Package with register map, field positions and types of the dual timer/counter block.
// Notes on behaviour
// - Counter 0 low byte at 8A, high byte at 8C, both reset to 00.
// - Counter 1 low byte at 8B, high byte at 8D, both reset to 00.
// - Combined control register at 88, reset value 00.
// - Mode register at 89, reset 00; upper nibble counter 1, lower counter 0.
// - Tick rate select register at 8E, reset value 01.
// - Source bit (6 / 2) one selects event counting, zero selects timer.
// - Counter 1 gate set: advance only while pin 1 high and run bit set.
// - Counter 1 gate clear: advance whenever run bit set, pin ignored.
// - Counter 0 gate set: advance only while pin 0 high and run bit set.
// - Counter 0 gate clear: advance whenever run bit set, pin ignored.
// - Counter 1 mode from bits 5:4; codes 00..11 select modes 0..3.
// - Counter 0 mode from bits 1:0; codes 00..11 select modes 0..3.
// - Mode 0 is a 13-bit timer or event counter.
// - Mode 1 is a full 16-bit counter across both bytes.
// - Mode 2 is an 8-bit counter with automatic reload.
// - Mode 3 splits counter 0 into two 8-bit counters; counter 0 only.
// - Counter 1 in mode 3 stops and holds its value.
// - Mode 0 uses high byte plus low five bits; overflow on all-ones rollover.
// - Mode 2 low byte rollover sets overflow and reloads from unchanged high byte.
// - Mode 3 counter 0 high byte times, using counter 1 run bit and flag.
// - Hardware sets overflow flags; vector or software clears; software owns run bits.
package dtc_pkg;
    localparam logic [7:0] ADDR_CONTROL = 8'h88;
    localparam logic [7:0] ADDR_MODE    = 8'h89;
    localparam logic [7:0] ADDR_T0_LOW  = 8'h8a;
    localparam logic [7:0] ADDR_T1_LOW  = 8'h8b;
    localparam logic [7:0] ADDR_T0_HIGH = 8'h8c;
    localparam logic [7:0] ADDR_T1_HIGH = 8'h8d;
    localparam logic [7:0] ADDR_RATE    = 8'h8e;

    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_RATE = 8'h01;

    localparam int BIT_OVF1 = 7;
    localparam int BIT_RUN1 = 6;
    localparam int BIT_OVF0 = 5;
    localparam int BIT_RUN0 = 4;

    localparam int BIT_GATE = 3;
    localparam int BIT_SRC  = 2;
    localparam int NIB_W    = 4;
    localparam int RATE_BIT0 = 3;
    localparam int RATE_BIT1 = 4;

    localparam logic [7:0] LOW13_MASK = 8'h1f;
    localparam logic [7:0] BYTE_ONES  = 8'hff;
    localparam logic [4:0] LOW5_ONES  = 5'h1f;

    // Slow tick divider: a counter not selected for full rate ticks every 12 clocks.
    localparam logic [3:0] SLOW_DIV_LAST = 4'hb;

    typedef enum logic [1:0] {
        DTC_MODE_13 = 2'h0,
        DTC_MODE_16 = 2'h1,
        DTC_MODE_RELOAD = 2'h2,
        DTC_MODE_SPLIT = 2'h3
    } dtc_mode_t;

    typedef struct packed {
        logic      gate;
        logic      src;
        dtc_mode_t mode;
    } dtc_nibble_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dtc_sfr_req_t;
endpackage

/* File: src/dtc_timers.sv */
// Dual timer/event counter block with its special-function registers.
`timescale 1ns/1ns
module dtc_timers (
    input  wire logic                  clk,          // System clock, 250 MHz.
    input  wire logic                  sys_rst,      // Synchronous reset, active high.
    input  wire dtc_pkg::dtc_sfr_req_t sfr_req,      // Register bus request.
    output logic [7:0]                 sfr_rdata,    // Registered read data.
    output logic                       sfr_hit,      // Address belongs to this block.
    input  wire logic                  vector_ack_0, // Core vectors to counter 0 interrupt.
    input  wire logic                  vector_ack_1, // Core vectors to counter 1 interrupt.
    input  wire logic                  ext_irq_pin_0, // Gate pin for counter 0.
    input  wire logic                  ext_irq_pin_1, // Gate pin for counter 1.
    input  wire logic                  count_pin_0,  // Event input for counter 0.
    input  wire logic                  count_pin_1,  // Event input for counter 1.
    output logic                       overflow_flag_0, // Counter 0 overflow flag.
    output logic                       overflow_flag_1  // Counter 1 overflow flag.
);
    logic [7:0]          timer_control;
    logic [7:0]          timer_mode_select;
    logic [7:0]          tick_rate_select;
    logic [7:0]          timer0_count_low;
    logic [7:0]          timer0_count_high;
    logic [7:0]          timer1_count_low;
    logic [7:0]          timer1_count_high;
    logic [3:0]          slow_div;
    logic                slow_tick;
    logic                gate_lvl_0;
    logic                gate_lvl_1;
    logic                ev_fall_0;
    logic                ev_fall_1;
    logic                adv_0;
    logic                adv_1;
    logic                adv_0h;
    logic                ovf_0;
    logic                ovf_1;
    logic                ovf_0h;
    logic [7:0]          next_low0;
    logic [7:0]          next_high0;
    logic [7:0]          next_low1;
    logic [7:0]          next_high1;
    dtc_pkg::dtc_nibble_t cfg_0;
    dtc_pkg::dtc_nibble_t cfg_1;
    logic                run_bit_0;
    logic                run_bit_1;

    assign cfg_0     = timer_mode_select[dtc_pkg::NIB_W-1:0];
    assign cfg_1     = timer_mode_select[2*dtc_pkg::NIB_W-1:dtc_pkg::NIB_W];
    assign run_bit_0 = timer_control[dtc_pkg::BIT_RUN0];
    assign run_bit_1 = timer_control[dtc_pkg::BIT_RUN1];
    assign overflow_flag_0 = timer_control[dtc_pkg::BIT_OVF0];
    assign overflow_flag_1 = timer_control[dtc_pkg::BIT_OVF1];

    dtc_edge_sync u_gate0 (.clk(clk), .sys_rst(sys_rst), .pin(ext_irq_pin_0),
                           .level(gate_lvl_0), .fall());
    dtc_edge_sync u_gate1 (.clk(clk), .sys_rst(sys_rst), .pin(ext_irq_pin_1),
                           .level(gate_lvl_1), .fall());
    dtc_edge_sync u_cnt0 (.clk(clk), .sys_rst(sys_rst), .pin(count_pin_0),
                          .level(), .fall(ev_fall_0));
    dtc_edge_sync u_cnt1 (.clk(clk), .sys_rst(sys_rst), .pin(count_pin_1),
                          .level(), .fall(ev_fall_1));

    // Address decode for the hit output; the read data path decodes with its own case.
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a >= dtc_pkg::ADDR_CONTROL) && (a <= dtc_pkg::ADDR_RATE);
    endfunction

    // Tick source for a timer: full clock when its rate bit is set, else the slow tick.
    function automatic logic tick_of(input logic src, input logic fast, input logic ev,
                                     input logic slow);
        if (src) begin
            tick_of = ev;
        end else begin
            tick_of = fast | slow;
        end
    endfunction

    assign sfr_hit = is_mapped(sfr_req.addr);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            slow_div <= 4'h0;
        end else if (slow_div == dtc_pkg::SLOW_DIV_LAST) begin
            slow_div <= 4'h0;
        end else begin
            slow_div <= slow_div + 4'h1;
        end
    end
    assign slow_tick = (slow_div == dtc_pkg::SLOW_DIV_LAST);

    // Enable: run bit and either gate clear or gate pin high.
    always_comb begin
        adv_0 = run_bit_0 && (!cfg_0.gate || gate_lvl_0) &&
                tick_of(cfg_0.src, tick_rate_select[dtc_pkg::RATE_BIT0], ev_fall_0, slow_tick);
        adv_1 = run_bit_1 && (!cfg_1.gate || gate_lvl_1) &&
                tick_of(cfg_1.src, tick_rate_select[dtc_pkg::RATE_BIT1], ev_fall_1, slow_tick)
                && (cfg_1.mode != dtc_pkg::DTC_MODE_SPLIT);
        // The split high byte is always a timer under counter 1's run bit.
        adv_0h = run_bit_1 && (cfg_0.mode == dtc_pkg::DTC_MODE_SPLIT) &&
                 tick_of(1'b0, tick_rate_select[dtc_pkg::RATE_BIT0], 1'b0, slow_tick);
    end

    // Counter 0 next value and overflow.
    always_comb begin
        next_low0  = timer0_count_low;
        next_high0 = timer0_count_high;
        ovf_0      = 1'b0;
        ovf_0h     = 1'b0;
        case (cfg_0.mode)
            dtc_pkg::DTC_MODE_13: begin
                if (adv_0) begin
                    next_low0 = timer0_count_low + 8'h01;
                    if (timer0_count_low[4:0] == dtc_pkg::LOW5_ONES) begin
                        next_low0  = timer0_count_low & ~dtc_pkg::LOW13_MASK;
                        next_high0 = timer0_count_high + 8'h01;
                        ovf_0      = (timer0_count_high == dtc_pkg::BYTE_ONES);
                    end
                end
            end
            dtc_pkg::DTC_MODE_16: begin
                if (adv_0) begin
                    {next_high0, next_low0} = {timer0_count_high, timer0_count_low} + 16'h0001;
                    ovf_0 = ({timer0_count_high, timer0_count_low} == 16'hffff);
                end
            end
            dtc_pkg::DTC_MODE_RELOAD: begin
                if (adv_0) begin
                    if (timer0_count_low == dtc_pkg::BYTE_ONES) begin
                        next_low0 = timer0_count_high;
                        ovf_0     = 1'b1;
                    end else begin
                        next_low0 = timer0_count_low + 8'h01;
                    end
                end
            end
            dtc_pkg::DTC_MODE_SPLIT: begin
                if (adv_0) begin
                    next_low0 = timer0_count_low + 8'h01;
                    ovf_0     = (timer0_count_low == dtc_pkg::BYTE_ONES);
                end
                if (adv_0h) begin
                    next_high0 = timer0_count_high + 8'h01;
                    ovf_0h     = (timer0_count_high == dtc_pkg::BYTE_ONES);
                end
            end
            default: begin
                next_low0 = timer0_count_low;
            end
        endcase
    end

    // Counter 1 next value and overflow; mode 3 holds.
    always_comb begin
        next_low1  = timer1_count_low;
        next_high1 = timer1_count_high;
        ovf_1      = 1'b0;
        case (cfg_1.mode)
            dtc_pkg::DTC_MODE_13: begin
                if (adv_1) begin
                    next_low1 = timer1_count_low + 8'h01;
                    if (timer1_count_low[4:0] == dtc_pkg::LOW5_ONES) begin
                        next_low1  = timer1_count_low & ~dtc_pkg::LOW13_MASK;
                        next_high1 = timer1_count_high + 8'h01;
                        ovf_1      = (timer1_count_high == dtc_pkg::BYTE_ONES);
                    end
                end
            end
            dtc_pkg::DTC_MODE_16: begin
                if (adv_1) begin
                    {next_high1, next_low1} = {timer1_count_high, timer1_count_low} + 16'h0001;
                    ovf_1 = ({timer1_count_high, timer1_count_low} == 16'hffff);
                end
            end
            dtc_pkg::DTC_MODE_RELOAD: begin
                if (adv_1) begin
                    if (timer1_count_low == dtc_pkg::BYTE_ONES) begin
                        next_low1 = timer1_count_high;
                        ovf_1     = 1'b1;
                    end else begin
                        next_low1 = timer1_count_low + 8'h01;
                    end
                end
            end
            default: begin
                next_low1 = timer1_count_low;
            end
        endcase
    end

    // Count registers: a software write takes precedence over counting.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            timer0_count_low  <= dtc_pkg::RST_ZERO;
            timer0_count_high <= dtc_pkg::RST_ZERO;
            timer1_count_low  <= dtc_pkg::RST_ZERO;
            timer1_count_high <= dtc_pkg::RST_ZERO;
        end else begin
            timer0_count_low  <= (sfr_req.wr && sfr_req.addr == dtc_pkg::ADDR_T0_LOW)
                                 ? sfr_req.wdata : next_low0;
            timer0_count_high <= (sfr_req.wr && sfr_req.addr == dtc_pkg::ADDR_T0_HIGH)
                                 ? sfr_req.wdata : next_high0;
            timer1_count_low  <= (sfr_req.wr && sfr_req.addr == dtc_pkg::ADDR_T1_LOW)
                                 ? sfr_req.wdata : next_low1;
            timer1_count_high <= (sfr_req.wr && sfr_req.addr == dtc_pkg::ADDR_T1_HIGH)
                                 ? sfr_req.wdata : next_high1;
        end
    end

    // Control register: a hardware set wins over a clear in the same cycle.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            timer_control <= dtc_pkg::RST_ZERO;
        end else begin
            if (sfr_req.wr && sfr_req.addr == dtc_pkg::ADDR_CONTROL) begin
                timer_control <= sfr_req.wdata;
            end
            if (vector_ack_0) begin
                timer_control[dtc_pkg::BIT_OVF0] <= 1'b0;
            end
            if (vector_ack_1) begin
                timer_control[dtc_pkg::BIT_OVF1] <= 1'b0;
            end
            if (ovf_0) begin
                timer_control[dtc_pkg::BIT_OVF0] <= 1'b1;
            end
            if (ovf_1 || ovf_0h) begin
                timer_control[dtc_pkg::BIT_OVF1] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            timer_mode_select <= dtc_pkg::RST_ZERO;
            tick_rate_select  <= dtc_pkg::RST_RATE;
        end else begin
            if (sfr_req.wr && sfr_req.addr == dtc_pkg::ADDR_MODE) begin
                timer_mode_select <= sfr_req.wdata;
            end
            if (sfr_req.wr && sfr_req.addr == dtc_pkg::ADDR_RATE) begin
                tick_rate_select <= sfr_req.wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sfr_rdata <= dtc_pkg::RST_ZERO;
        end else if (sfr_req.rd) begin
            case (sfr_req.addr)
                dtc_pkg::ADDR_CONTROL: sfr_rdata <= timer_control;
                dtc_pkg::ADDR_MODE:    sfr_rdata <= timer_mode_select;
                dtc_pkg::ADDR_T0_LOW:  sfr_rdata <= timer0_count_low;
                dtc_pkg::ADDR_T1_LOW:  sfr_rdata <= timer1_count_low;
                dtc_pkg::ADDR_T0_HIGH: sfr_rdata <= timer0_count_high;
                dtc_pkg::ADDR_T1_HIGH: sfr_rdata <= timer1_count_high;
                dtc_pkg::ADDR_RATE:    sfr_rdata <= tick_rate_select;
                default:               sfr_rdata <= dtc_pkg::RST_ZERO;
            endcase
        end
    end

    reload_keeps_high_a: assert property (@(posedge clk) disable iff (sys_rst)
        (cfg_0.mode == dtc_pkg::DTC_MODE_RELOAD && adv_0 && timer0_count_low == 8'hff &&
         !sfr_req.wr) |=> (timer0_count_low == $past(timer0_count_high) &&
         timer0_count_high == $past(timer0_count_high) && overflow_flag_0))
        else $error("Reload did not copy high byte or set flag.");
    t1_split_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        (cfg_1.mode == dtc_pkg::DTC_MODE_SPLIT && !sfr_req.wr) |=>
        $stable({timer1_count_high, timer1_count_low}))
        else $error("Counter 1 moved in mode 3.");
    gate_block_a: assert property (@(posedge clk) disable iff (sys_rst)
        (cfg_0.gate && !gate_lvl_0) |-> !adv_0)
        else $error("Counter 0 advanced with gate low.");
    stop_block_a: assert property (@(posedge clk) disable iff (sys_rst)
        !run_bit_1 |-> !adv_1)
        else $error("Counter 1 advanced with run bit clear.");
    wrap16_a: assert property (@(posedge clk) disable iff (sys_rst)
        (cfg_0.mode == dtc_pkg::DTC_MODE_16 && adv_0 && !sfr_req.wr &&
         {timer0_count_high, timer0_count_low} == 16'hffff) |=>
        ({timer0_count_high, timer0_count_low} == 16'h0000 && overflow_flag_0))
        else $error("16-bit wrap wrong.");
    wrap13_a: assert property (@(posedge clk) disable iff (sys_rst)
        (cfg_1.mode == dtc_pkg::DTC_MODE_13 && adv_1 && !sfr_req.wr &&
         timer1_count_high == 8'hff && timer1_count_low[4:0] == 5'h1f) |=>
        (timer1_count_high == 8'h00 && timer1_count_low[4:0] == 5'h00 && overflow_flag_1))
        else $error("13-bit wrap wrong.");
    split_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
        (adv_0h && timer0_count_high == 8'hff && !sfr_req.wr) |=> overflow_flag_1)
        else $error("Split high byte overflow missed flag 1.");
    event_count_a: assert property (@(posedge clk) disable iff (sys_rst)
        (cfg_0.src && !ev_fall_0) |-> !adv_0)
        else $error("Event counter advanced without an edge.");
    step16_a: assert property (@(posedge clk) disable iff (sys_rst)
        (cfg_0.mode == dtc_pkg::DTC_MODE_16 && adv_0 && !sfr_req.wr) |=>
        ({timer0_count_high, timer0_count_low} ==
         $past({timer0_count_high, timer0_count_low}) + 16'h0001))
        else $error("Counter 0 did not step by one in mode 1.");
    free_run0_a: assert property (@(posedge clk) disable iff (sys_rst)
        (run_bit_0 && !cfg_0.gate && !cfg_0.src && slow_tick) |-> adv_0)
        else $error("Counter 0 missed a tick with gate clear.");
    free_run1_a: assert property (@(posedge clk) disable iff (sys_rst)
        (run_bit_1 && !cfg_1.gate && !cfg_1.src && slow_tick &&
         cfg_1.mode != dtc_pkg::DTC_MODE_SPLIT) |-> adv_1)
        else $error("Counter 1 missed a tick with gate clear.");
endmodule // dtc_timers

/* File: testbench/dtc_cpu_model.sv */
// Core model that issues register bus cycles and interrupt vector acknowledges.
`timescale 1ns/1ns
module dtc_cpu_model (
    input  wire logic             clk,   // System clock.
    output dtc_pkg::dtc_sfr_req_t req,   // Register bus request.
    output logic                  ack_0, // Vector taken for counter 0.
    output logic                  ack_1  // Vector taken for counter 1.
);
    initial begin
        req   = '0;
        ack_0 = 1'b0;
        ack_1 = 1'b0;
    end

    // A released bus shows inverted address and data so stale values never match.
    task automatic cycle(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge clk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cycle(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        cycle(1'b0, a, 8'h00);
    endtask

    task automatic ack(input logic c);
        @(negedge clk);
        if (c) ack_1 <= 1'b1;
        else ack_0 <= 1'b1;
        @(negedge clk);
        ack_0 <= 1'b0;
        ack_1 <= 1'b0;
    endtask
endmodule // dtc_cpu_model

/* File: testbench/dual_timer_counter_block_bench.sv */
// Self-checking bench for the dual timer/counter block.
`timescale 1ns/1ns
module dual_timer_counter_block_bench;
    logic                  clk = 1'b0;
    logic                  sys_rst = 1'b1;
    dtc_pkg::dtc_sfr_req_t req;
    logic [7:0]            sfr_rdata;
    logic                  sfr_hit;
    logic                  ack_0;
    logic                  ack_1;
    logic [1:0]            ovf;
    logic [1:0]            gate_pin = 2'h3;
    logic [1:0]            cnt_pin = 2'h3;
    logic [7:0]            exp_q[$];
    logic                  pend = 1'b0;
    int                    miscompares = 0;
    int                    checks = 0;
    int                    cycles = 0;
    integer                seed = 32'h37efbb90;

    always #2 clk = ~clk;

    dtc_cpu_model u_cpu (.clk(clk), .req(req), .ack_0(ack_0), .ack_1(ack_1));

    dtc_timers u_dut (
        .clk(clk), .sys_rst(sys_rst), .sfr_req(req), .sfr_rdata(sfr_rdata),
        .sfr_hit(sfr_hit), .vector_ack_0(ack_0), .vector_ack_1(ack_1),
        .ext_irq_pin_0(gate_pin[0]), .ext_irq_pin_1(gate_pin[1]),
        .count_pin_0(cnt_pin[0]), .count_pin_1(cnt_pin[1]),
        .overflow_flag_0(ovf[0]), .overflow_flag_1(ovf[1])
    );

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic expect_rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        u_cpu.rd(a);
    endtask

    task automatic wait_flag(input logic c, input int lim);
        for (int n = 0; n < lim && ovf[c] !== 1'b1; n++) @(negedge clk);
        check("flag set", {7'h0, ovf[c]}, 8'h01);
    endtask

    // Loads a counter, runs it slowly to overflow, then stops it just after the wrap.
    task automatic ovf_case(input logic c, input logic [1:0] m, input logic g,
                            input logic [7:0] lo, input logic [7:0] hi,
                            input logic [7:0] elo, input logic [7:0] ehi);
        logic [3:0] nib;
        nib = {g, 1'b0, m};
        gate_pin[c] = 1'b0;
        u_cpu.wr({7'h45, c}, lo);
        u_cpu.wr({7'h46, c}, hi);
        u_cpu.wr(8'h89, c ? {nib, 4'h0} : {4'h0, nib});
        u_cpu.wr(8'h88, c ? 8'h40 : 8'h10);
        if (g) begin
            repeat (40) @(negedge clk);
            check("gated flag", {7'h0, ovf[c]}, 8'h00);
            gate_pin[c] = 1'b1;
        end
        wait_flag(c, 80);
        u_cpu.ack(c);
        check("vector clear", {7'h0, ovf[c]}, 8'h00);
        u_cpu.wr(8'h88, 8'h00);
        expect_rd({7'h45, c}, elo);
        expect_rd({7'h46, c}, ehi);
    endtask

    always @(posedge clk) begin
        pend <= req.rd;
        cycles <= cycles + 1;
        if (req.rd) check("hit", {7'h0, sfr_hit},
                          {7'h0, (req.addr inside {[8'h88:8'h8e]})});
        if (cycles == 20000) begin
            miscompares++;
            summarize();
        end
    end

    always @(negedge clk) begin
        if (pend) check("read data", sfr_rdata, exp_q.pop_front());
    end

    initial begin
        logic [7:0] d[8];
        int n;
        repeat (5) @(negedge clk);
        sys_rst = 1'b0;
        for (int a = 8'h87; a <= 8'h8f; a++) expect_rd(8'(a), (a == 8'h8e) ? 8'h01 : 8'h00);
        for (int a = 1; a < 7; a++) begin
            d[a] = 8'($random(seed));
            u_cpu.wr(8'(8'h88 + a), d[a]);
        end
        d[0] = 8'($random(seed)) & 8'haf;
        u_cpu.wr(8'h88, d[0]);
        u_cpu.wr(8'h90, 8'h5a);
        for (int a = 0; a < 7; a++) expect_rd(8'(8'h88 + a), d[a]);
        expect_rd(8'h90, 8'h00);
        u_cpu.wr(8'h88, 8'h00);
        u_cpu.wr(8'h8e, 8'h00);
        for (int c = 0; c < 2; c++) begin
            ovf_case(c[0], 2'h0, 1'b0, 8'hfe, 8'hff, 8'he0, 8'h00);
            ovf_case(c[0], 2'h1, 1'b1, 8'hfe, 8'hff, 8'h00, 8'h00);
            ovf_case(c[0], 2'h2, 1'b0, 8'hfe, 8'ha5, 8'ha5, 8'ha5);
        end
        for (int c = 0; c < 2; c++) begin
            n = ($random(seed) & 7) + 1;
            u_cpu.wr({7'h45, c[0]}, 8'h00);
            u_cpu.wr(8'h89, c ? 8'h50 : 8'h05);
            u_cpu.wr(8'h88, c ? 8'h40 : 8'h10);
            repeat (n) begin
                cnt_pin[c] = 1'b0;
                repeat (6) @(negedge clk);
                cnt_pin[c] = 1'b1;
                repeat (6) @(negedge clk);
            end
            u_cpu.wr(8'h88, 8'h00);
            expect_rd({7'h45, c[0]}, 8'(n));
        end
        u_cpu.wr(8'h89, 8'h33);
        u_cpu.wr(8'h8b, 8'h55);
        u_cpu.wr(8'h8a, 8'hfe);
        u_cpu.wr(8'h8c, 8'hff);
        u_cpu.wr(8'h88, 8'h40);
        wait_flag(1'b1, 60);
        u_cpu.wr(8'h88, 8'h10);
        expect_rd(8'h8b, 8'h55);
        expect_rd(8'h8a, 8'hfe);
        expect_rd(8'h8c, 8'h00);
        wait_flag(1'b0, 60);
        u_cpu.wr(8'h88, 8'h00);
        u_cpu.wr(8'h8e, 8'h08);
        u_cpu.wr(8'h89, 8'h02);
        u_cpu.wr(8'h8a, 8'h00);
        u_cpu.wr(8'h88, 8'h10);
        repeat (200) @(negedge clk);
        check("fast early", {7'h0, ovf[0]}, 8'h00);
        wait_flag(1'b0, 100);
        // A reset in mid-run must bring the counter 0 low byte, rate and control registers back while a counter is running.
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        expect_rd(8'h8a, 8'h00);
        expect_rd(8'h8e, 8'h01);
        expect_rd(8'h88, 8'h00);
        check("flag reset", {7'h0, ovf[0]}, 8'h00);
        repeat (4) @(negedge clk);
        summarize();
    end
endmodule // dual_timer_counter_block_bench
